// >>> logic/fault_diag_pkg.sv
// package: register map, field positions and constants for the fault status bank
package fault_diag_pkg;
    localparam logic [7:0] ERR_SUMMARY_ADDR = 8'h00;
    localparam logic [7:0] PHASE_A_ADDR = 8'h01;
    localparam logic [7:0] PHASE_B_ADDR = 8'h02;
    localparam logic [7:0] PHASE_C_ADDR = 8'h03;
    localparam logic [7:0] TEST_CFG_ADDR = 8'h05;
    // summary register fields
    localparam int ANY_ERROR_BIT = 7;
    localparam int GATE_DRIVE_ERROR_BIT = 6;
    localparam int PUMP_UNDERVOLTAGE_BIT = 5;
    localparam int SUPPLY_UNDERVOLTAGE_LOCK_BIT = 4;
    localparam int OVERCURRENT_TRIP_BIT = 3;
    localparam int OVERTEMP_WARNING_BIT = 2;
    localparam int OVERTEMP_SHUTDOWN_BIT = 1;
    localparam int OPEN_OR_SHORT_SUMMARY_BIT = 0;
    // per-phase register fields
    localparam int SENSE_AMP_OC_BIT = 7;
    localparam int GROUND_SHORT_BIT = 6;
    localparam int BATTERY_SHORT_BIT = 5;
    localparam int OPEN_LOAD_BIT = 4;
    localparam int LOW_GATE_SRC_BIT = 3;
    localparam int HIGH_GATE_SRC_BIT = 2;
    localparam int LOW_DRAIN_SRC_BIT = 1;
    localparam int HIGH_DRAIN_SRC_BIT = 0;
    // test configuration fields
    localparam int PASSIVE_OPEN_LOAD_TEST_EN_BIT = 0;
    localparam int SHORT_TEST_EN_BIT = 1;
    // reset values and sizes
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int NUM_PHASES = 3;
    localparam int REG_W = 8;
    // undervoltage threshold in millivolts
    localparam logic [15:0] SUPPLY_UNDERVOLTAGE_LOCK_THRESHOLD_MV = 16'd6000;
endpackage

// >>> logic/phase_fault_if.sv
// interface: per-phase fault detect lines and latched status between top and latch
`timescale 1ns/1ps
interface phase_fault_if;
    logic [7:0] detect;
    logic [7:0] status;
    modport top (output detect, input status);
    modport latch (input detect, output status);
endinterface

// >>> logic/phase_status_latch.sv
// module: sticky latch for one per-phase diagnostic status register
`timescale 1ns/1ps
module phase_status_latch
    import fault_diag_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic clear_i,
    phase_fault_if.latch pf
);
    logic [7:0] status_r;
    logic [7:0] status_nxt;

    always_comb begin
        status_nxt = status_r;
        if (clear_i) begin
            status_nxt = STATUS_RESET;
        end
        // a detection in the clear cycle is kept
        status_nxt = status_nxt | pf.detect;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_r <= STATUS_RESET;
        end else if (clk_en_i) begin
            status_r <= status_nxt;
        end
    end

    assign pf.status = status_r;

    a_phase_sticky_bits: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (clk_en_i && !clear_i) |=> ((status_r & $past(status_r)) == $past(status_r)))
        else $error("phase status bit dropped without clear");
endmodule

// >>> logic/gate_driver_fault_diag_status.sv
// module: fault and diagnostic status register bank of a three-phase gate driver
// Contract
// - Any fault sets its own status bit and drives the active-low error output low.
// - Summary register 0x00 holds any-error, gate-drive, pump uv, supply supply_undervoltage_lock, oc, otw, overtemp_shutdown, open/short.
// - Phase registers 0x01-0x03 hold sense oc, gnd short, bat short, open load, vgs l/h, vds l/h.
// - An open load found sets the phase open-load bit, the open/short summary and the error output.
// - A short found sets the phase short bit, the open/short summary and the error output.
// - Supply below 6 V sets the undervoltage lock bit and error output; other faults are readable.
`timescale 1ns/1ps
module gate_driver_fault_diag_status
    import fault_diag_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic fault_clear_i,
    input wire logic gate_drive_error_i,
    input wire logic pump_undervoltage_i,
    input wire logic [15:0] supply_mv_i,
    input wire logic overcurrent_trip_i,
    input wire logic overtemp_warning_i,
    input wire logic overtemp_shutdown_i,
    input wire logic [2:0] sense_amp_overcurrent_i,
    input wire logic [2:0] low_gate_src_err_i,
    input wire logic [2:0] high_gate_src_err_i,
    input wire logic [2:0] low_drain_src_err_i,
    input wire logic [2:0] high_drain_src_err_i,
    input wire logic [2:0] open_load_seen_i,
    input wire logic [2:0] ground_short_seen_i,
    input wire logic [2:0] battery_short_seen_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic passive_open_load_test_en_o,
    output logic short_test_en_o,
    output logic error_out_n_o
);
    import fault_diag_pkg::*;

    phase_fault_if pf[NUM_PHASES] ();
    logic [NUM_PHASES-1:0] phase_any;
    logic [NUM_PHASES-1:0] phase_open_short;
    logic [NUM_PHASES-1:0] phase_os_det;
    logic [NUM_PHASES-1:0] phase_any_nxt;

    logic [6:0] summary_r;
    logic [6:0] summary_nxt;
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic err_n_r;
    logic err_n_nxt;
    logic [7:0] summary_view;

    function automatic logic is_status_addr(input logic [7:0] a);
        return (a == ERR_SUMMARY_ADDR) || (a == PHASE_A_ADDR) ||
               (a == PHASE_B_ADDR) || (a == PHASE_C_ADDR);
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_PHASES; g++) begin : gen_phase
            logic ol_det;
            logic sh_det;
            // detection only counts while its test is enabled
            assign ol_det = open_load_seen_i[g] && cfg_r[PASSIVE_OPEN_LOAD_TEST_EN_BIT];
            assign sh_det = short_test_en_o && cfg_r[SHORT_TEST_EN_BIT];
            assign pf[g].detect = {sense_amp_overcurrent_i[g],
                                   ground_short_seen_i[g] && sh_det,
                                   battery_short_seen_i[g] && sh_det,
                                   ol_det,
                                   low_gate_src_err_i[g],
                                   high_gate_src_err_i[g],
                                   low_drain_src_err_i[g],
                                   high_drain_src_err_i[g]};
            assign phase_any[g] = |pf[g].status;
            assign phase_open_short[g] = pf[g].status[GROUND_SHORT_BIT] |
                                         pf[g].status[BATTERY_SHORT_BIT] |
                                         pf[g].status[OPEN_LOAD_BIT];
            // open/short detections, taken on the same edge as the phase latch
            assign phase_os_det[g] = pf[g].detect[GROUND_SHORT_BIT] |
                                     pf[g].detect[BATTERY_SHORT_BIT] |
                                     pf[g].detect[OPEN_LOAD_BIT];
            // next phase content, so the error pin moves together with the latch
            assign phase_any_nxt[g] = |((fault_clear_i ? STATUS_RESET : pf[g].status) |
                                        pf[g].detect);
            phase_status_latch u_latch (
                .sys_clk_i(sys_clk_i),
                .nrst_i(nrst_i),
                .clk_en_i(clk_en_i),
                .clear_i(fault_clear_i),
                .pf(pf[g])
            );
        end
    endgenerate

    // summary fault latching, set wins over clear
    always_comb begin
        summary_nxt = fault_clear_i ? STATUS_RESET[6:0] : summary_r;
        if (gate_drive_error_i) begin
            summary_nxt[GATE_DRIVE_ERROR_BIT] = 1'b1;
        end
        if (pump_undervoltage_i) begin
            summary_nxt[PUMP_UNDERVOLTAGE_BIT] = 1'b1;
        end
        if (supply_mv_i < SUPPLY_UNDERVOLTAGE_LOCK_THRESHOLD_MV) begin
            summary_nxt[SUPPLY_UNDERVOLTAGE_LOCK_BIT] = 1'b1;
        end
        if (overcurrent_trip_i) begin
            summary_nxt[OVERCURRENT_TRIP_BIT] = 1'b1;
        end
        if (overtemp_warning_i) begin
            summary_nxt[OVERTEMP_WARNING_BIT] = 1'b1;
        end
        if (overtemp_shutdown_i) begin
            summary_nxt[OVERTEMP_SHUTDOWN_BIT] = 1'b1;
        end
        if (|phase_os_det) begin
            summary_nxt[OPEN_OR_SHORT_SUMMARY_BIT] = 1'b1;
        end
    end

    assign summary_view = {err_n_r == 1'b0, summary_r};

    // configuration register holds the test enables
    always_comb begin
        cfg_nxt = cfg_r;
        if (reg_wr_i && reg_addr_i == TEST_CFG_ADDR) begin
            cfg_nxt = reg_wdata_i;
        end
    end

    // read path and error pin; writes to status addresses fall through untouched
    always_comb begin
        rvalid_nxt = reg_rd_i;
        case (reg_addr_i)
            ERR_SUMMARY_ADDR: rdata_nxt = summary_view;
            PHASE_A_ADDR: rdata_nxt = pf[0].status;
            PHASE_B_ADDR: rdata_nxt = pf[1].status;
            PHASE_C_ADDR: rdata_nxt = pf[2].status;
            TEST_CFG_ADDR: rdata_nxt = cfg_r;
            default: rdata_nxt = 8'h00;
        endcase
        if (!reg_rd_i) begin
            rdata_nxt = rdata_r;
        end
        err_n_nxt = !((|summary_nxt) || (|phase_any_nxt));
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            summary_r <= STATUS_RESET[6:0];
            cfg_r <= CFG_RESET;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            err_n_r <= 1'b1;
        end else if (clk_en_i) begin
            summary_r <= summary_nxt;
            cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            err_n_r <= err_n_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;
    assign passive_open_load_test_en_o = cfg_r[PASSIVE_OPEN_LOAD_TEST_EN_BIT];
    assign short_test_en_o = cfg_r[SHORT_TEST_EN_BIT];
    assign error_out_n_o = err_n_r;

    a_supply_undervoltage_lock_sets_error: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (clk_en_i && supply_mv_i < SUPPLY_UNDERVOLTAGE_LOCK_THRESHOLD_MV) |=>
        (summary_r[SUPPLY_UNDERVOLTAGE_LOCK_BIT] && !error_out_n_o))
        else $error("undervoltage did not set lock bit and error pin");
    a_fault_drives_pin: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (clk_en_i && (gate_drive_error_i || overcurrent_trip_i)) |=> !error_out_n_o)
        else $error("fault did not assert error pin");
    a_open_load_flags: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (clk_en_i && open_load_seen_i[1] && passive_open_load_test_en_o) |=>
        (pf[1].status[OPEN_LOAD_BIT] && summary_view[OPEN_OR_SHORT_SUMMARY_BIT]))
        else $error("open load not flagged");
    a_short_flags: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (clk_en_i && ground_short_seen_i[0] && short_test_en_o) |=>
        (pf[0].status[GROUND_SHORT_BIT] && summary_view[OPEN_OR_SHORT_SUMMARY_BIT]))
        else $error("short not flagged");
    a_status_write_ignored: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (clk_en_i && reg_wr_i && is_status_addr(reg_addr_i)) |=> $stable(cfg_r))
        else $error("status write changed configuration");
    a_read_returns_phase: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (clk_en_i && reg_rd_i && reg_addr_i == PHASE_C_ADDR) |=>
        (reg_rvalid_o && reg_rdata_o == $past(pf[2].status)))
        else $error("phase c read data wrong");
    a_summary_any_bit: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        !error_out_n_o == ((|summary_r) || (|phase_any)))
        else $error("error pin disagrees with latched bits");
    a_test_enable_write: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (clk_en_i && reg_wr_i && reg_addr_i == TEST_CFG_ADDR) |=>
        (short_test_en_o == $past(reg_wdata_i[SHORT_TEST_EN_BIT])))
        else $error("test enable write not stored");
    a_open_short_summary: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        summary_r[OPEN_OR_SHORT_SUMMARY_BIT] == (|phase_open_short))
        else $error("open/short summary disagrees with phase bits");
    a_open_load_gated: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (!passive_open_load_test_en_o && !pf[1].status[OPEN_LOAD_BIT]) |=>
        !pf[1].status[OPEN_LOAD_BIT])
        else $error("open load latched with its test off");
    a_short_gated: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (!short_test_en_o && !pf[0].status[GROUND_SHORT_BIT]) |=>
        !pf[0].status[GROUND_SHORT_BIT])
        else $error("short latched with its test off");
    a_unmapped_reads_zero: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        (clk_en_i && reg_rd_i && !is_status_addr(reg_addr_i) && reg_addr_i != TEST_CFG_ADDR)
        |=> (reg_rdata_o == 8'h00))
        else $error("unmapped read returned nonzero data");
    a_enable_freezes: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        !clk_en_i |=> ($stable(summary_r) && $stable(cfg_r) && $stable(error_out_n_o) &&
                       $stable(reg_rvalid_o)))
        else $error("state moved while clock enable low");
endmodule

// >>> tb/host_model.sv
// host side model: register reads and writes launched at the falling edge
`timescale 1ns/1ps
module host_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge sys_clk_i);
        reg_rd_o = 1'b0;
        v = reg_rvalid_i;
        d = reg_rdata_i;
    endtask
endmodule

// >>> tb/gate_driver_fault_diag_status_tb.sv
// testbench: fault status bank driven through its register strobes
`timescale 1ns/1ps
module gate_driver_fault_diag_status_tb;
    import fault_diag_pkg::*;
    logic sys_clk_i, nrst_i, clk_en_i, fault_clear_i, gde, puv, oc, overtemp_warning, overtemp_shutdown;
    logic [15:0] supply_mv;
    logic [2:0] sense_amp_a_overcurrent, lgs, hgs, lds, hds, ol, gs, bs, pm;
    logic reg_wr, reg_rd, rvalid, ol_en, sh_en, err_n, v;
    logic [7:0] addr, wdata, rdata, d, sm;
    logic [7:0] fb [5] = '{8'h80, 8'h08, 8'h04, 8'h02, 8'h01};
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    host_model host (.sys_clk_i(sys_clk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(addr), .reg_wdata_o(wdata));
    gate_driver_fault_diag_status DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .clk_en_i(clk_en_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .fault_clear_i(fault_clear_i), .gate_drive_error_i(gde),
        .pump_undervoltage_i(puv), .supply_mv_i(supply_mv), .overcurrent_trip_i(oc),
        .overtemp_warning_i(overtemp_warning), .overtemp_shutdown_i(overtemp_shutdown),
        .sense_amp_overcurrent_i(sense_amp_a_overcurrent), .low_gate_src_err_i(lgs), .high_gate_src_err_i(hgs),
        .low_drain_src_err_i(lds), .high_drain_src_err_i(hds), .open_load_seen_i(ol),
        .ground_short_seen_i(gs), .battery_short_seen_i(bs), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .passive_open_load_test_en_o(ol_en), .short_test_en_o(sh_en),
        .error_out_n_o(err_n));
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d, v);
        chk1("rvalid", 1'b1, v);
        chk8($sformatf("reg %h", a), e, d);
    endtask
    task automatic settle();
        repeat (3) @(negedge sys_clk_i);
    endtask
    task automatic quiet();
        {gde, puv, oc, overtemp_warning, overtemp_shutdown, sense_amp_a_overcurrent, lgs, hgs, lds, hds, ol, gs, bs} = '0;
        supply_mv = 16'd12000;
        fault_clear_i = 1'b1;
        settle();
        fault_clear_i = 1'b0;
        settle();
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        nrst_i = 1'b0;
        clk_en_i = 1'b1;
        fault_clear_i = 1'b0;
        {gde, puv, oc, overtemp_warning, overtemp_shutdown, sense_amp_a_overcurrent, lgs, hgs, lds, hds, ol, gs, bs} = '0;
        supply_mv = 16'd12000;
        repeat (10) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        chk1("error_out_n", 1'b1, err_n);
        for (int a = 0; a < 5; a++) rdchk(8'(a), STATUS_RESET);
        $display("test reset done");
        supply_mv = 16'd6000;
        settle();
        chk1("error_out_n", 1'b1, err_n);
        supply_mv = 16'd5999;
        settle();
        chk1("error_out_n", 1'b0, err_n);
        rdchk(ERR_SUMMARY_ADDR, 8'h90);
        supply_mv = 16'd12000;
        host.wr(ERR_SUMMARY_ADDR, 8'h00);
        rdchk(ERR_SUMMARY_ADDR, 8'h90);
        quiet();
        rdchk(ERR_SUMMARY_ADDR, 8'h00);
        chk1("error_out_n", 1'b1, err_n);
        $display("test undervoltage done");
        for (int i = 1; i < 7; i++) begin
            if (i == 4) continue;
            sm = 8'h01 << i;
            {gde, puv, oc, overtemp_warning, overtemp_shutdown} = {sm[6], sm[5], sm[3], sm[2], sm[1]};
            settle();
            rdchk(ERR_SUMMARY_ADDR, 8'h80 | sm);
            chk1("error_out_n", 1'b0, err_n);
            quiet();
        end
        $display("test summary done");
        for (int p = 0; p < 3; p++) begin
            for (int f = 0; f < 5; f++) begin
                pm = 3'b001 << p;
                sense_amp_a_overcurrent = fb[f][7] ? pm : 3'b000;
                lgs = fb[f][3] ? pm : 3'b000;
                hgs = fb[f][2] ? pm : 3'b000;
                lds = fb[f][1] ? pm : 3'b000;
                hds = fb[f][0] ? pm : 3'b000;
                settle();
                for (int q = 0; q < 3; q++) rdchk(8'(q + 1), (q == p) ? fb[f] : 8'h00);
                chk1("error_out_n", 1'b0, err_n);
                quiet();
            end
        end
        $display("test phase done");
        ol = 3'b010;
        settle();
        rdchk(PHASE_B_ADDR, 8'h00);
        host.wr(TEST_CFG_ADDR, 8'h01);
        settle();
        chk1("open_load_en", 1'b1, ol_en);
        rdchk(PHASE_B_ADDR, 8'h10);
        rdchk(ERR_SUMMARY_ADDR, 8'h81);
        chk1("error_out_n", 1'b0, err_n);
        quiet();
        gs = 3'b001;
        bs = 3'b100;
        settle();
        rdchk(PHASE_A_ADDR, 8'h00);
        host.wr(TEST_CFG_ADDR, 8'h02);
        settle();
        chk1("short_en", 1'b1, sh_en);
        rdchk(PHASE_A_ADDR, 8'h40);
        rdchk(PHASE_C_ADDR, 8'h20);
        rdchk(ERR_SUMMARY_ADDR, 8'h81);
        chk1("error_out_n", 1'b0, err_n);
        {gs, bs} = '0;
        host.wr(PHASE_C_ADDR, 8'h00);
        rdchk(PHASE_C_ADDR, 8'h20);
        $display("test self checks done");
        quiet();
        clk_en_i = 1'b0;
        gde = 1'b1;
        host.rd(ERR_SUMMARY_ADDR, d, v);
        chk1("rvalid_frozen", 1'b0, v);
        settle();
        chk1("error_out_n", 1'b1, err_n);
        gde = 1'b0;
        clk_en_i = 1'b1;
        rdchk(ERR_SUMMARY_ADDR, 8'h00);
        $display("test clock enable done");
        tally_and_finish();
    end
endmodule
